// ==== hw/psd_port.sv ====
// port pin sensing, interrupts, events, pin drive and direction registers
`timescale 1ns/10ps
module psd_port
    import psd_pkg::*;
#(
    parameter int         NPINS     = 8,
    parameter int         NCH       = 8,
    parameter int         ASYNC_PIN = 2,
    parameter logic [3:0] PORT_ID   = 4'h0
)
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // pins
    input  wire logic [NPINS-1:0] pin_in,
    output logic      [NPINS-1:0] pin_out,
    output logic      [NPINS-1:0] pin_oe_n,
    // output value from the data register block
    input  wire logic [NPINS-1:0] out_value,
    // alternate function overrides
    input  wire logic [NPINS-1:0] ovr_dir_en,
    input  wire logic [NPINS-1:0] ovr_dir,
    input  wire logic [NPINS-1:0] ovr_out_en,
    input  wire logic [NPINS-1:0] ovr_out,
    // event channels to drive out
    input  wire logic [NCH-1:0]   evch,
    // virtual port writes
    input  wire logic             vp_wen,
    input  wire logic [1:0]       vp_slot,
    input  wire logic [1:0]       vp_reg,
    input  wire logic [7:0]       vp_wdata,
    // power state
    input  wire logic             sleep,
    input  wire logic             instr_done,
    output logic                  wake,
    // interrupts and events
    output logic      [1:0]       interrupt_request,
    output logic      [NPINS-1:0] evt_signal,
    output logic      [NPINS-1:0] evt_data
);
    import psd_pkg::*;

    // ==========================================================
    // registers
    logic [NPINS-1:0] pin_direction_r;
    logic [NPINS-1:0] pin_direction_nxt;
    logic [3:0]       intctrl_r;
    logic [NPINS-1:0] first_irq_source_mask_r;
    logic [NPINS-1:0] second_irq_source_mask_r;
    logic [1:0]       port_irq_flag_r;
    logic [1:0]       port_irq_flag_nxt;
    logic [7:0]       pinctrl_r [NPINS];
    logic [NPINS-1:0] mpc_mask_r;
    logic [7:0]       event_output_select_r;
    logic [3:0]       vp_map_r [4];
    logic [31:0]      prdata_r;

    // sensing state
    logic [NPINS-1:0] in_r;
    logic [NPINS-1:0] prev_r;
    logic [NPINS-1:0] snap_r;
    logic [NPINS-1:0] lat_r;
    logic [NPINS-1:0] hit;
    logic [NPINS-1:0] wake_src;
    logic [NPINS-1:0] evt_sig_nxt;
    logic [NPINS-1:0] pv;
    logic             sleep_d_r;
    logic [7:0]       wake_cnt_r;
    logic             wake_r;
    logic             clk_on;
    logic             wake_end;

    // bus decode
    logic [5:0]       widx;
    logic             addr_ok;
    logic             wr_en;
    logic [7:0]       wbyte;
    logic [7:0]       rd_val;
    logic             vp_hit;
    logic [1:0]       flag_set;
    logic [1:0]       flag_clr;
    logic [1:0]       evmode;
    logic [2:0]       evpin;
    logic [2:0]       evchan;

    assign widx    = paddr[7:2];
    assign wbyte   = pwdata[7:0];
    assign wr_en   = psel & penable & pwrite & addr_ok & pstrb[0];
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_r;
    assign vp_hit  = vp_wen & (vp_map_r[vp_slot] == PORT_ID);     // see RL15
    assign evmode  = event_output_select_r[PSD_EVMODE_LSB +: 2];
    assign evpin   = event_output_select_r[PSD_EVPIN_LSB +: 3];
    assign evchan  = event_output_select_r[PSD_EVCHAN_LSB +: 3];
    assign clk_on  = ~sleep & (wake_cnt_r == 8'h00);
    assign wake_end = (wake_cnt_r == 8'h01);

    // ==========================================================
    // address decode and read mux
    always_comb
    begin
        addr_ok = (paddr[1:0] == 2'h0);
        rd_val  = 8'h00;
        if (widx == PSD_IDX_DIR || widx == PSD_IDX_DIR_SET ||
            widx == PSD_IDX_DIR_CLR || widx == PSD_IDX_DIR_TGL)
            rd_val = pin_direction_r;                    // see RL17
        else if (widx == PSD_IDX_INTCTRL)
            rd_val = {4'h0, intctrl_r};
        else if (widx == PSD_IDX_INT0_MASK)
            rd_val = first_irq_source_mask_r;
        else if (widx == PSD_IDX_INT1_MASK)
            rd_val = second_irq_source_mask_r;
        else if (widx == PSD_IDX_INTFLAGS)
            rd_val = {6'h00, port_irq_flag_r};
        else if (widx[5:3] == PSD_IDX_PINCTRL0[5:3])
            rd_val = pinctrl_r[widx[2:0]];
        else if (widx == PSD_IDX_MPCMASK)
            rd_val = mpc_mask_r;
        else if (widx == PSD_IDX_EVOUT)
            rd_val = event_output_select_r;
        else if (widx >= PSD_IDX_VPMAP0 && widx <= PSD_IDX_VPMAP0 + 6'h03)
            rd_val = {4'h0, vp_map_r[2'(widx - PSD_IDX_VPMAP0)]};
        else
            addr_ok = 1'b0;
    end

    // read data is captured in the setup phase, valid in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h00000000;
        else if (psel & ~penable)
            prdata_r <= {24'h000000, rd_val};
    end

    // ==========================================================
    // direction register and its aliases
    always_comb
    begin
        pin_direction_nxt = pin_direction_r;
        if (vp_hit && vp_reg == PSD_VP_DIR)
            pin_direction_nxt = vp_wdata;                // see RL15
        if (wr_en)
        begin
            case (widx)
                PSD_IDX_DIR:     pin_direction_nxt = wbyte;   // see RL16
                PSD_IDX_DIR_SET: pin_direction_nxt = pin_direction_r | wbyte;
                PSD_IDX_DIR_CLR: pin_direction_nxt = pin_direction_r & ~wbyte;
                PSD_IDX_DIR_TGL: pin_direction_nxt = pin_direction_r ^ wbyte;
                default:         ;
            endcase
        end
    end
    // set, clear and toggle above: see RL17 see RL18 see RL19 see RL22

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_direction_r <= PSD_RST_REG;              // see RL16
        else
            pin_direction_r <= pin_direction_nxt;
    end

    // ==========================================================
    // interrupt control, masks, event output select, multi-pin mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            intctrl_r                <= 4'h0;
            first_irq_source_mask_r  <= PSD_RST_REG;
            second_irq_source_mask_r <= PSD_RST_REG;
            event_output_select_r    <= PSD_RST_REG;
        end
        else if (wr_en)
        begin
            if (widx == PSD_IDX_INTCTRL)
                intctrl_r <= wbyte[3:0];
            if (widx == PSD_IDX_INT0_MASK)
                first_irq_source_mask_r <= wbyte;
            if (widx == PSD_IDX_INT1_MASK)
                second_irq_source_mask_r <= wbyte;
            if (widx == PSD_IDX_EVOUT)
                event_output_select_r <= wbyte;
        end
    end

    // mask empties after one pin control write has used it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mpc_mask_r <= PSD_RST_REG;
        else if (wr_en && widx == PSD_IDX_MPCMASK)
            mpc_mask_r <= wbyte;
        else if (wr_en && widx[5:3] == PSD_IDX_PINCTRL0[5:3])
            mpc_mask_r <= '0;                            // see RL14
    end

    // ==========================================================
    // virtual port slots
    for (genvar k = 0; k < 4; k++)
    begin : g_vp
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                vp_map_r[k] <= 4'h0;
            else if (wr_en && widx == PSD_IDX_VPMAP0 + 6'(k))
                vp_map_r[k] <= wbyte[3:0];               // see RL15
        end
    end

    // ==========================================================
    // sleep tracking and wake-up window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_d_r  <= 1'b0;
            wake_cnt_r <= 8'h00;
            snap_r     <= '0;
            wake_r     <= 1'b0;
        end
        else
        begin
            sleep_d_r <= sleep;
            // snapshot follows the pins while clocked, frozen asleep
            if (clk_on)
                snap_r <= in_r;
            if (sleep_d_r & ~sleep)
                wake_cnt_r <= 8'(PSD_WAKE_CYC);
            else if (wake_cnt_r != 8'h00)
                wake_cnt_r <= wake_cnt_r - 8'h01;
            wake_r <= sleep & (|wake_src);               // see RL5 see RL8
        end
    end
    assign wake = wake_r;

    // ==========================================================
    // per-pin sensing, events and pin drive
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
        psd_sense_type isc;
        logic          pp;
        logic          sp;
        logic          edge_hit;
        logic          drive_sel;

        assign isc = psd_sense_type'(pinctrl_r[i][PSD_ISC_LSB +: 3]);
        assign pv[i] = in_r[i] ^ pinctrl_r[i][PSD_INVEN_BIT];
        assign pp = prev_r[i] ^ pinctrl_r[i][PSD_INVEN_BIT];
        assign sp = snap_r[i] ^ pinctrl_r[i][PSD_INVEN_BIT];

        // edge between the two latest clocked samples
        always_comb
        begin
            unique case (isc)
                PSD_SENSE_BOTH: edge_hit = pv[i] ^ pp;
                PSD_SENSE_RISE: edge_hit = pv[i] & ~pp;
                PSD_SENSE_FALL: edge_hit = ~pv[i] & pp;
                default:        edge_hit = 1'b0;
            endcase
        end

        // pin control, written singly or through the multi-pin mask
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                pinctrl_r[i] <= PSD_RST_REG;
            else if (wr_en && widx[5:3] == PSD_IDX_PINCTRL0[5:3] &&
                     (mpc_mask_r != '0 ? mpc_mask_r[i]
                                       : widx[2:0] == 3'(i)))
                pinctrl_r[i] <= wbyte;                   // see RL14
        end

        // clockless edge latch on the fully asynchronous pin
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                lat_r[i] <= 1'b0;
            else if (i != ASYNC_PIN || wake_end)
                lat_r[i] <= 1'b0;
            else if (~clk_on & edge_hit)
                lat_r[i] <= 1'b1;                        // see RL4
        end

        // sources that wake the device while it sleeps
        always_comb
        begin
            if (i == ASYNC_PIN)
                wake_src[i] = lat_r[i] | edge_hit;       // see RL4
            else
                wake_src[i] = (isc == PSD_SENSE_BOTH) & (pv[i] ^ sp);
            if (isc == PSD_SENSE_LOW && !pv[i])
                wake_src[i] = 1'b1;                      // see RL6
        end

        // interrupt hits, clocked and at wake end
        always_comb
        begin
            hit[i] = 1'b0;
            if (clk_on && isc == PSD_SENSE_LOW)
                hit[i] = ~pv[i] & instr_done;            // see RL7
            else if (clk_on)
                hit[i] = edge_hit;                       // see RL3
            if (wake_end && isc == PSD_SENSE_LOW && !pv[i])
                hit[i] = 1'b1;                           // see RL8
            else if (wake_end && i == ASYNC_PIN && lat_r[i])
                hit[i] = 1'b1;                           // see RL4
            else if (wake_end && i != ASYNC_PIN && isc == PSD_SENSE_BOTH)
                hit[i] = pv[i] ^ sp;                     // see RL5
        end

        // event signal chosen by the sense setting
        assign evt_sig_nxt[i] = (isc == PSD_SENSE_LOW) ? pv[i] : edge_hit;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                in_r[i]       <= 1'b0;
                prev_r[i]     <= 1'b0;
                evt_signal[i] <= 1'b0;
                evt_data[i]   <= 1'b0;
            end
            else
            begin
                in_r[i]       <= pin_in[i];
                prev_r[i]     <= in_r[i];
                evt_signal[i] <= clk_on & evt_sig_nxt[i];  // see RL9 see RL10
                evt_data[i]   <= clk_on & pv[i];           // see RL11
            end
        end

        // pin drive: event or clock output, then overrides, then port
        assign drive_sel = (evmode != PSD_EVOUT_OFF) && (evpin == 3'(i));
        always_comb
        begin
            if (drive_sel && evmode == PSD_EVOUT_CLOCK)
                pin_out[i] = pclk;                       // see RL13
            else if (drive_sel)
                pin_out[i] = evch[evchan];               // see RL13
            else if (ovr_out_en[i])
                pin_out[i] = ovr_out[i] ^ pinctrl_r[i][PSD_INVEN_BIT];
            else
                pin_out[i] = out_value[i] ^ pinctrl_r[i][PSD_INVEN_BIT];
            pin_oe_n[i] = ~(drive_sel |
                (ovr_dir_en[i] ? ovr_dir[i] : pin_direction_r[i]));
        end
        // override selection above: see RL12
    end

    // ==========================================================
    // port interrupt flags and requests
    assign flag_set[0] = |(hit & first_irq_source_mask_r);   // see RL20
    assign flag_set[1] = |(hit & second_irq_source_mask_r);  // see RL1
    assign flag_clr = (wr_en && widx == PSD_IDX_INTFLAGS ? wbyte[1:0] : 2'h0)
                    | (vp_hit && vp_reg == PSD_VP_FLAGS ? vp_wdata[1:0]
                                                        : 2'h0);
    // a set in the clearing cycle wins
    assign port_irq_flag_nxt = (port_irq_flag_r & ~flag_clr) | flag_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_irq_flag_r <= 2'h0;
        else
            port_irq_flag_r <= port_irq_flag_nxt;        // see RL21
    end

    assign interrupt_request[0] = port_irq_flag_r[0] &
        (intctrl_r[PSD_LVL0_LSB +: 2] != 2'h0);          // see RL2
    assign interrupt_request[1] = port_irq_flag_r[1] &
        (intctrl_r[PSD_LVL1_LSB +: 2] != 2'h0);          // see RL2

    // ==========================================================
    // assertions
    a_dir_set_bits: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && widx == PSD_IDX_DIR_SET |=>
        pin_direction_r == ($past(pin_direction_r) | $past(wbyte)))
        else $error("direction set alias wrong");        // see RL17
    a_dir_clr_bits: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && widx == PSD_IDX_DIR_CLR && !vp_wen |=>
        pin_direction_r == ($past(pin_direction_r) & ~$past(wbyte)))
        else $error("direction clear alias wrong");      // see RL18
    a_dir_tgl_bits: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && widx == PSD_IDX_DIR_TGL && !vp_wen |=>
        pin_direction_r == ($past(pin_direction_r) ^ $past(wbyte)))
        else $error("direction toggle alias wrong");     // see RL19
    a_alias_reads: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr[7:4] == 4'h0 ##1
        psel && penable |-> prdata[7:0] == pin_direction_r)
        else $error("alias read not direction");         // see RL17
    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        intctrl_r[1:0] == 2'h0 |-> !interrupt_request[0])
        else $error("request while disabled");           // see RL2
    a_flag_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (hit & second_irq_source_mask_r) != '0 |=> port_irq_flag_r[1])
        else $error("masked source lost");               // see RL21
    a_flag_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
        !port_irq_flag_r[0] && (hit & first_irq_source_mask_r) == '0 |=>
        !port_irq_flag_r[0])
        else $error("flag set without source");          // see RL20
    a_evt_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        sleep |=> evt_signal == '0)
        else $error("event while sleeping");             // see RL9
    a_wake_window: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_d_r && !sleep |=> wake_cnt_r == 8'(PSD_WAKE_CYC))
        else $error("wake window not started");          // see RL8
    a_edge_event: assert property (@(posedge pclk) disable iff (!presetn)
        clk_on && pinctrl_r[0][2:0] == 3'h1 && pv[0] && !prev_r[0] &&
        !pinctrl_r[0][PSD_INVEN_BIT] |=> evt_signal[0])
        else $error("rising edge event missing");        // see RL11

endmodule // psd_port

// ==== include/psd_pkg.sv ====
// constants for the port sense and direction block
//
// Notes on behaviour
// RL1: two port interrupt requests, each with its own pin source selection.
// RL2: no request leaves the port until its level field is non-zero.
// RL3: clocked sensing supports all senses; edges count after one clocked sample.
// RL4: pin 2 latches any configured edge without a clock, always interrupts.
// RL5: other pins sleeping: any-edge and low wake; interrupt only if value held.
// RL6: low level detected always; requests repeat while the pin stays low.
// RL7: awake, low level interrupts only if still low when instruction completes.
// RL8: asleep, low level wakes; interrupt only if still low at wake end.
// RL9: events only while the clock runs, edges after one clocked sample.
// RL10: level sense events: low gives none, high gives continuous events.
// RL11: sense selects the signal event; the data event is the pin value.
// RL12: enabled alternate function overrides pin direction and value internally.
// RL13: clock or chosen event channel driven to a selectable pin.
// RL14: one pin control write updates every pin chosen by the multi-pin mask.
// RL15: four virtual slots map a port; virtual writes act on real registers.
// RL16: direction register at index zero, one means output, resets to zero.
// RL17: ones written to the set alias set direction bits; reads give direction.
// RL18: ones written to the clear alias clear bits; reads give direction.
// RL19: ones written to the toggle alias invert bits; reads give direction.
// RL20: a pin feeds an interrupt only when its source mask bit is one.
// RL21: flag sets on a matching selected pin, cleared by writing one.
// RL22: zero bits written to set, clear or toggle aliases change nothing.
package psd_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] PSD_IDX_DIR       = 6'h00;
    localparam logic [5:0] PSD_IDX_DIR_SET   = 6'h01;
    localparam logic [5:0] PSD_IDX_DIR_CLR   = 6'h02;
    localparam logic [5:0] PSD_IDX_DIR_TGL   = 6'h03;
    localparam logic [5:0] PSD_IDX_INTCTRL   = 6'h09;
    localparam logic [5:0] PSD_IDX_INT0_MASK = 6'h0A;
    localparam logic [5:0] PSD_IDX_INT1_MASK = 6'h0B;
    localparam logic [5:0] PSD_IDX_INTFLAGS  = 6'h0C;
    localparam logic [5:0] PSD_IDX_PINCTRL0  = 6'h10;
    localparam logic [5:0] PSD_IDX_MPCMASK   = 6'h18;
    localparam logic [5:0] PSD_IDX_EVOUT     = 6'h19;
    localparam logic [5:0] PSD_IDX_VPMAP0    = 6'h1A;

    // ==========================================================
    // field positions
    localparam int PSD_ISC_LSB    = 0;
    localparam int PSD_INVEN_BIT  = 6;
    localparam int PSD_LVL0_LSB   = 0;
    localparam int PSD_LVL1_LSB   = 2;
    localparam int PSD_EVPIN_LSB  = 0;
    localparam int PSD_EVMODE_LSB = 3;
    localparam int PSD_EVCHAN_LSB = 5;

    // ==========================================================
    // reset values
    localparam logic [7:0] PSD_RST_REG = 8'h00;

    // ==========================================================
    // sense settings and event output modes
    typedef enum logic [2:0] {
        PSD_SENSE_BOTH = 3'h0,
        PSD_SENSE_RISE = 3'h1,
        PSD_SENSE_FALL = 3'h2,
        PSD_SENSE_LOW  = 3'h3
    } psd_sense_type;

    localparam logic [1:0] PSD_EVOUT_OFF   = 2'h0;
    localparam logic [1:0] PSD_EVOUT_CLOCK = 2'h1;
    localparam logic [1:0] PSD_EVOUT_EVENT = 2'h2;

    // virtual port register selects
    localparam logic [1:0] PSD_VP_DIR   = 2'h0;
    localparam logic [1:0] PSD_VP_FLAGS = 2'h3;

    // ==========================================================
    // timing
    localparam int PSD_PCLK_KHZ  = 40000;
    localparam int PSD_WAKE_NS   = 500;
    localparam int PSD_WAKE_CYC  = (PSD_WAKE_NS * PSD_PCLK_KHZ + 999999)
                                   / 1000000;

endpackage

// ==== tb/psd_pin_model.sv ====
// external circuit model that drives and senses the port pins
`timescale 1ns/10ps
module psd_pin_model
(
    // outside drive and port pins
    input  wire logic [7:0] drive,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    output logic      [7:0] pin_in
);
    // wire follows the port where it drives, else the outside circuit
    assign pin_in = (pin_out & ~pin_oe_n) | (drive & pin_oe_n);
endmodule // psd_pin_model

// ==== tb/tb_port_sense_and_direction.sv ====
// self-checking bench for the port sense and direction block
`timescale 1ns/10ps
module tb_port_sense_and_direction;
    import psd_pkg::*;
    // ==========================================================
    // signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, wake, err;
    logic        sleep = 1'b0;
    logic        instr_done = 1'b0;
    logic        vp_wen = 1'b0;
    logic [7:0]  drive = 8'h00;
    logic [7:0]  zero8 = 8'h00;
    logic [7:0]  vp_wdata = 8'h00;
    logic [7:0]  pin_in, pin_out, pin_oe_n, evt_signal, evt_data;
    logic [1:0]  irq;
    int          failures = 0;
    int          check_count = 0;
    int          n;
    always #12.5 pclk = ~pclk;
    psd_port u_psd_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .out_value(8'hA5), .ovr_dir_en(zero8),
        .ovr_dir(zero8), .ovr_out_en(zero8), .ovr_out(zero8),
        .evch(zero8), .vp_wen(vp_wen), .vp_slot(2'h0), .vp_reg(PSD_VP_DIR),
        .vp_wdata(vp_wdata), .sleep(sleep), .instr_done(instr_done),
        .wake(wake), .interrupt_request(irq), .evt_signal(evt_signal),
        .evt_data(evt_data));
    psd_pin_model u_psd_pin_model (.drive(drive), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_in(pin_in));
    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] i, input [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk("read", rd, {24'h0, e});
    endtask
    task automatic pulse_done;
        @(posedge pclk);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_dir;
        rdc(PSD_IDX_DIR, 8'h00);
        apb(1'b1, PSD_IDX_DIR, 8'h3C);
        #1;
        chk("oe_n", pin_oe_n, 8'hC3);
        apb(1'b1, PSD_IDX_DIR_SET, 8'h81);
        rdc(PSD_IDX_DIR_SET, 8'hBD);
        apb(1'b1, PSD_IDX_DIR_CLR, 8'h0C);
        rdc(PSD_IDX_DIR_CLR, 8'hB1);
        apb(1'b1, PSD_IDX_DIR_TGL, 8'h0F);
        rdc(PSD_IDX_DIR_TGL, 8'hBE);
        apb(1'b0, 6'h3F, 8'h00);
        chk("slverr", err, 1);
        @(posedge pclk);
        vp_wen <= 1'b1;
        vp_wdata <= 8'h5A;
        @(posedge pclk);
        vp_wen <= 1'b0;
        rdc(PSD_IDX_DIR, 8'h5A);
        apb(1'b1, PSD_IDX_DIR, 8'h00);
    endtask
    task automatic t_edge;
        apb(1'b1, PSD_IDX_PINCTRL0, 8'(PSD_SENSE_RISE));
        apb(1'b1, PSD_IDX_INT0_MASK, 8'h01);
        @(posedge pclk);
        drive[0] <= 1'b1;
        n = 0;
        while (evt_signal[0] !== 1'b1 && n < 8)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("evt_lat", n, 2);
        chk("evt_dat", evt_data[0], 1);
        @(posedge pclk);
        #1;
        chk("evt_len", evt_signal[0], 0);
        chk("irq_off", irq, 0);
        rdc(PSD_IDX_INTFLAGS, 8'h01);
        apb(1'b1, PSD_IDX_INTCTRL, 8'h05);
        #1;
        chk("irq_on", irq, 1);
        apb(1'b1, PSD_IDX_INTFLAGS, 8'h01);
        rdc(PSD_IDX_INTFLAGS, 8'h00);
    endtask
    task automatic t_low;
        apb(1'b1, PSD_IDX_PINCTRL0 + 6'h01, 8'(PSD_SENSE_LOW));
        apb(1'b1, PSD_IDX_INT1_MASK, 8'h02);
        rdc(PSD_IDX_INTFLAGS, 8'h00);
        chk("lvl_evt", evt_signal[1], 0);
        pulse_done();
        rdc(PSD_IDX_INTFLAGS, 8'h02);
        chk("irq1", irq, 2);
        apb(1'b1, PSD_IDX_INTFLAGS, 8'h02);
        rdc(PSD_IDX_INTFLAGS, 8'h00);
        pulse_done();
        rdc(PSD_IDX_INTFLAGS, 8'h02);
    endtask
    task automatic t_wake;
        apb(1'b1, PSD_IDX_PINCTRL0 + 6'h02, 8'(PSD_SENSE_RISE));
        apb(1'b1, PSD_IDX_INT0_MASK, 8'h04);
        apb(1'b1, PSD_IDX_INTFLAGS, 8'h03);
        sleep <= 1'b1;
        repeat (3) @(posedge pclk);
        drive[2] <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk("wake", wake, 1);
        @(posedge pclk);
        sleep <= 1'b0;
        repeat (PSD_WAKE_CYC + 2) @(posedge pclk);
        rdc(PSD_IDX_INTFLAGS, 8'h03);
        chk("wake_off", wake, 0);
    endtask
    task automatic t_pins;
        apb(1'b1, PSD_IDX_MPCMASK, 8'h30);
        apb(1'b1, PSD_IDX_PINCTRL0, 8'h43);
        rdc(PSD_IDX_PINCTRL0 + 6'h05, 8'h43);
        rdc(PSD_IDX_PINCTRL0, 8'(PSD_SENSE_RISE));
        chk("lvl_inv", evt_signal[5:4], 2'h3);
        apb(1'b1, PSD_IDX_EVOUT, 8'h17);
        #1;
        chk("ev_pin", {pin_out[7], pin_oe_n[7]}, 2'h0);
    endtask
    // ==========================================================
    // run control
    task automatic print_verdict;
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_dir();
        t_edge();
        t_low();
        t_wake();
        t_pins();
        print_verdict();
    end
    initial
    begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule // tb_port_sense_and_direction
